/* logic/pawb_bridge.sv */
// cpu to peripheral bus bridge with access wait generation and axi4-lite control
`timescale 1ns/1ps
module pawb_bridge (
  input  wire logic                         clk,
  input  wire logic                         rstn,
  // axi4-lite control slave
  input  wire logic [pawb_pkg::AXI_AW-1:0]  s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [pawb_pkg::AXI_AW-1:0]  s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  // cpu side
  input  wire logic                         cpu_req,
  input  wire logic                         cpu_we,
  input  wire logic [pawb_pkg::PADDR_W-1:0] cpu_addr,
  input  wire logic [pawb_pkg::PDATA_W-1:0] cpu_wdata,
  output logic                              cpu_wait,
  output logic                              cpu_done,
  output logic [pawb_pkg::PDATA_W-1:0]      cpu_rdata,
  // peripheral side
  input  wire logic                         pclk_in,
  output logic                              per_sel,
  output logic                              per_we,
  output logic [pawb_pkg::PADDR_W-1:0]      per_addr,
  output logic [pawb_pkg::PDATA_W-1:0]      per_wdata,
  input  wire logic [pawb_pkg::PDATA_W-1:0] per_rdata,
  // peripheral state
  input  wire logic                         wdt_running,
  input  wire logic                         rto_enable,
  input  wire logic                         sub_main_stopped,
  input  wire logic                         on_internal_osc
);
  typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_STUCK} pawb_state_t;

  logic                          pclk_s;
  logic                          sub_stop_s;
  logic                          int_osc_s;
  logic [pawb_pkg::PDATA_W-1:0]  prd_s;
  pawb_pkg::pawb_class_t         cls;
  logic [pawb_pkg::K_W-1:0]      k_lo;
  logic [pawb_pkg::K_W-1:0]      k_hi;
  logic [pawb_pkg::K_W-1:0]      k_sel;
  logic [3:0]                    wi;
  logic [3:0]                    wj;
  logic [pawb_pkg::TOT_W-1:0]    tot;
  logic                          prohib;

  pawb_state_t                   state_ff, nxt_state;
  logic [pawb_pkg::TOT_W-1:0]    cnt_ff, nxt_cnt;
  logic                          wait_ff, nxt_wait;
  logic                          done_ff, nxt_done;
  logic [pawb_pkg::PDATA_W-1:0]  rdata_ff, nxt_rdata;
  logic                          sel_ff, nxt_sel;
  logic                          we_ff, nxt_we;
  logic [pawb_pkg::PADDR_W-1:0]  addr_ff, nxt_addr;
  logic [pawb_pkg::PDATA_W-1:0]  wdata_ff, nxt_wdata;
  logic                          prev_cmp_ff, nxt_prev_cmp;
  logic [pawb_pkg::K_W-1:0]      k_ff, nxt_k;
  logic [pawb_pkg::TOT_W-1:0]    tot_ff, nxt_tot;
  logic [15:0]                   acnt_ff, nxt_acnt;

  logic [7:0]                    swc_ff, nxt_swc;
  logic                          aw_ff, nxt_aw;
  logic [pawb_pkg::AXI_AW-1:0]   awa_ff, nxt_awa;
  logic                          wd_ff, nxt_wd;
  logic [7:0]                    wdb_ff, nxt_wdb;
  logic                          wst_ff, nxt_wst;
  logic                          bv_ff, nxt_bv;
  logic [1:0]                    br_ff, nxt_br;
  logic                          rv_ff, nxt_rv;
  logic [31:0]                   rd_ff, nxt_rd;
  logic [1:0]                    rr_ff, nxt_rr;

  pawb_sync #(.W(1)) u_pclk_sync (.clk(clk), .rstn(rstn), .d(pclk_in), .q(pclk_s));
  pawb_sync #(.W(2)) u_ck_sync (
    .clk (clk),
    .rstn(rstn),
    .d   ({sub_main_stopped, on_internal_osc}),
    .q   ({sub_stop_s, int_osc_s})
  );
  // peripheral holds read data still through the stall; a per-bit two-flop copy
  // of a wide word could tear, and would come too late for a three-clock read
  assign prd_s = per_rdata;

  pawb_kdec u_kdec (
    .addr       (cpu_addr),
    .we         (cpu_we),
    .wdt_running(wdt_running),
    .rto_enable (rto_enable),
    .prev_cmp_wr(prev_cmp_ff),
    .cls        (cls),
    .k_lo       (k_lo),
    .k_hi       (k_hi)
  );

  // a high synced peripheral clock means an edge is near, so the short count is unsafe
  assign k_sel  = pclk_s ? k_hi : k_lo;
  assign wi     = swc_ff[7:4];
  assign wj     = swc_ff[3:0];
  assign tot    = pawb_pkg::BASE_CYC + {4'h0, wi} + {4'h0, wj}
                + 8'((pawb_pkg::STROBE_ADD + {4'h0, wj}) * {5'h0, k_sel});
  assign prohib = sub_stop_s | int_osc_s;

  // access sequencer
  always_comb begin
    nxt_state    = state_ff;
    nxt_cnt      = cnt_ff;
    nxt_done     = 1'b0;
    nxt_rdata    = rdata_ff;
    nxt_sel      = sel_ff;
    nxt_we       = we_ff;
    nxt_addr     = addr_ff;
    nxt_wdata    = wdata_ff;
    nxt_prev_cmp = prev_cmp_ff;
    nxt_k        = k_ff;
    nxt_tot      = tot_ff;
    nxt_acnt     = acnt_ff;
    case (state_ff)
      ST_IDLE: begin
        // done cycle still sees the old request, so it is not taken again
        if (cpu_req && !done_ff) begin
          nxt_acnt = acnt_ff + 16'h0001;
          if (prohib && (k_hi != pawb_pkg::K_NONE)) begin
            nxt_state = ST_STUCK;
          end else begin
            nxt_state    = ST_ACCESS;
            nxt_cnt      = tot - 8'h02;
            nxt_sel      = 1'b1;
            nxt_we       = cpu_we;
            nxt_addr     = cpu_addr;
            nxt_wdata    = cpu_wdata;
            nxt_prev_cmp = cpu_we && (cls == pawb_pkg::PC_TCMP);
            nxt_k        = k_sel;
            nxt_tot      = tot;
          end
        end
      end
      ST_ACCESS: begin
        if (cnt_ff == 8'h00) begin
          nxt_state = ST_IDLE;
          nxt_done  = 1'b1;
          nxt_sel   = 1'b0;
          if (!we_ff) nxt_rdata = prd_s;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      ST_STUCK: nxt_state = ST_STUCK;
      default:  nxt_state = ST_IDLE;
    endcase
    nxt_wait = (nxt_state != ST_IDLE);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff    <= ST_IDLE;
      cnt_ff      <= '0;
      wait_ff     <= 1'b0;
      done_ff     <= 1'b0;
      rdata_ff    <= '0;
      sel_ff      <= 1'b0;
      we_ff       <= 1'b0;
      addr_ff     <= '0;
      wdata_ff    <= '0;
      prev_cmp_ff <= 1'b0;
      k_ff        <= '0;
      tot_ff      <= '0;
      acnt_ff     <= '0;
    end else begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      wait_ff     <= nxt_wait;
      done_ff     <= nxt_done;
      rdata_ff    <= nxt_rdata;
      sel_ff      <= nxt_sel;
      we_ff       <= nxt_we;
      addr_ff     <= nxt_addr;
      wdata_ff    <= nxt_wdata;
      prev_cmp_ff <= nxt_prev_cmp;
      k_ff        <= nxt_k;
      tot_ff      <= nxt_tot;
      acnt_ff     <= nxt_acnt;
    end
  end

  // axi4-lite slave, one write and one read in flight
  always_comb begin
    nxt_swc = swc_ff;
    nxt_aw  = aw_ff;
    nxt_awa = awa_ff;
    nxt_wd  = wd_ff;
    nxt_wdb = wdb_ff;
    nxt_wst = wst_ff;
    nxt_bv  = bv_ff;
    nxt_br  = br_ff;
    nxt_rv  = rv_ff;
    nxt_rd  = rd_ff;
    nxt_rr  = rr_ff;
    if (s_axi_awvalid && !aw_ff && !bv_ff) begin
      nxt_aw  = 1'b1;
      nxt_awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wd_ff && !bv_ff) begin
      nxt_wd  = 1'b1;
      nxt_wdb = s_axi_wdata[7:0];
      nxt_wst = s_axi_wstrb[0];
    end
    if (aw_ff && wd_ff) begin
      nxt_aw = 1'b0;
      nxt_wd = 1'b0;
      nxt_bv = 1'b1;
      nxt_br = pawb_pkg::RESP_OK;
      if (awa_ff == pawb_pkg::SWC_OFF) begin
        if (wst_ff) nxt_swc = wdb_ff;
      end else if (awa_ff != pawb_pkg::STAT_OFF && awa_ff != pawb_pkg::ACNT_OFF) begin
        nxt_br = pawb_pkg::RESP_ERR;
      end
    end
    if (bv_ff && s_axi_bready) nxt_bv = 1'b0;
    if (s_axi_arvalid && !rv_ff) begin
      nxt_rv = 1'b1;
      nxt_rr = pawb_pkg::RESP_OK;
      case (s_axi_araddr)
        pawb_pkg::SWC_OFF:  nxt_rd = {24'h000000, swc_ff};
        pawb_pkg::STAT_OFF: nxt_rd = {16'h0000, (state_ff == ST_STUCK), wait_ff,
                                      prev_cmp_ff, 2'h0, k_ff, tot_ff};
        pawb_pkg::ACNT_OFF: nxt_rd = {16'h0000, acnt_ff};
        default: begin
          nxt_rd = 32'h00000000;
          nxt_rr = pawb_pkg::RESP_ERR;
        end
      endcase
    end else if (rv_ff && s_axi_rready) begin
      nxt_rv = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      swc_ff <= pawb_pkg::SWC_RST;
      aw_ff  <= 1'b0;
      awa_ff <= '0;
      wd_ff  <= 1'b0;
      wdb_ff <= '0;
      wst_ff <= 1'b0;
      bv_ff  <= 1'b0;
      br_ff  <= '0;
      rv_ff  <= 1'b0;
      rd_ff  <= '0;
      rr_ff  <= '0;
    end else begin
      swc_ff <= nxt_swc;
      aw_ff  <= nxt_aw;
      awa_ff <= nxt_awa;
      wd_ff  <= nxt_wd;
      wdb_ff <= nxt_wdb;
      wst_ff <= nxt_wst;
      bv_ff  <= nxt_bv;
      br_ff  <= nxt_br;
      rv_ff  <= nxt_rv;
      rd_ff  <= nxt_rd;
      rr_ff  <= nxt_rr;
    end
  end

  assign s_axi_awready = ~aw_ff & ~bv_ff;
  assign s_axi_wready  = ~wd_ff & ~bv_ff;
  assign s_axi_bvalid  = bv_ff;
  assign s_axi_bresp   = br_ff;
  assign s_axi_arready = ~rv_ff;
  assign s_axi_rvalid  = rv_ff;
  assign s_axi_rdata   = rd_ff;
  assign s_axi_rresp   = rr_ff;
  assign cpu_wait      = wait_ff;
  assign cpu_done      = done_ff;
  assign cpu_rdata     = rdata_ff;
  assign per_sel       = sel_ff;
  assign per_we        = we_ff;
  assign per_addr      = addr_ff;
  assign per_wdata     = wdata_ff;

  // cycles since the access was taken, only for checking
  logic [pawb_pkg::TOT_W-1:0] len_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) len_ff <= '0;
    else if (state_ff == ST_IDLE) len_ff <= 8'h01;
    else len_ff <= len_ff + 8'h01;
  end

  total_len_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(done_ff) |-> len_ff == tot_ff)
    else $error("access length differs from formula");
  stall_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    state_ff == ST_ACCESS |-> wait_ff && !done_ff)
    else $error("cpu not stalled during access");
  stuck_stay_a: assert property (@(posedge clk) disable iff (!rstn)
    state_ff == ST_STUCK |=> state_ff == ST_STUCK && wait_ff)
    else $error("stuck stall released without reset");
  prohib_stuck_a: assert property (@(posedge clk) disable iff (!rstn)
    state_ff == ST_IDLE && cpu_req && !done_ff && prohib && k_hi != pawb_pkg::K_NONE
    |=> state_ff == ST_STUCK)
    else $error("prohibited access did not stall");
  plain_three_a: assert property (@(posedge clk) disable iff (!rstn)
    state_ff == ST_IDLE && cpu_req && !done_ff && !prohib && k_hi == pawb_pkg::K_NONE
    && swc_ff == 8'h00 |-> ##3 done_ff)
    else $error("plain access not three clocks");
  cmp_first_a: assert property (@(posedge clk) disable iff (!rstn)
    cls == pawb_pkg::PC_TCMP && cpu_we && !prev_cmp_ff |-> k_hi == pawb_pkg::K_NONE)
    else $error("first compare write got extra factor");
  phase_k_a: assert property (@(posedge clk) disable iff (!rstn)
    state_ff == ST_IDLE && cpu_req && !done_ff && pclk_s && !prohib
    |=> k_ff == $past(k_hi))
    else $error("larger k not chosen on late phase");
  addr_held_a: assert property (@(posedge clk) disable iff (!rstn)
    state_ff == ST_ACCESS |=> $stable(addr_ff) && $stable(we_ff))
    else $error("peripheral address changed in stall");
  wdt_k_a: assert property (@(posedge clk) disable iff (!rstn)
    cls == pawb_pkg::PC_WDM && cpu_we && wdt_running |-> k_lo == pawb_pkg::K_THREE)
    else $error("watchdog write factor wrong");
  bvalid_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    bv_ff && !s_axi_bready |=> bv_ff)
    else $error("write response dropped");

  cov_extra_c: cover property (@(posedge clk) disable iff (!rstn) $rose(done_ff) && k_ff != 3'h0);
  cov_cmp_c:   cover property (@(posedge clk) disable iff (!rstn) k_ff == pawb_pkg::K_FOUR);
  cov_stuck_c: cover property (@(posedge clk) disable iff (!rstn) state_ff == ST_STUCK);
endmodule // pawb_bridge

/* logic/pawb_kdec.sv */
// classifies a peripheral access and gives its smaller and larger k factor
`timescale 1ns/1ps
module pawb_kdec (
  input  wire logic [pawb_pkg::PADDR_W-1:0] addr,
  input  wire logic                         we,
  input  wire logic                         wdt_running,
  input  wire logic                         rto_enable,
  input  wire logic                         prev_cmp_wr,
  output pawb_pkg::pawb_class_t             cls,
  output logic [pawb_pkg::K_W-1:0]          k_lo,
  output logic [pawb_pkg::K_W-1:0]          k_hi
);
  always_comb begin
    cls  = pawb_pkg::pawb_decode(addr);
    k_lo = pawb_pkg::K_NONE;
    k_hi = pawb_pkg::K_NONE;
    case (cls)
      pawb_pkg::PC_TCNT, pawb_pkg::PC_CMODE, pawb_pkg::PC_CRES, pawb_pkg::PC_CRESH: begin
        if (!we) begin
          k_lo = pawb_pkg::K_ONE;
          k_hi = pawb_pkg::K_TWO;
        end
      end
      pawb_pkg::PC_TCMP: begin
        if (!we) begin
          k_lo = pawb_pkg::K_ONE;
          k_hi = pawb_pkg::K_TWO;
        end else if (prev_cmp_wr) begin
          k_lo = pawb_pkg::K_THREE;
          k_hi = pawb_pkg::K_FOUR;
        end
      end
      pawb_pkg::PC_WDM: begin
        if (we && wdt_running) begin
          k_lo = pawb_pkg::K_THREE;
          k_hi = pawb_pkg::K_THREE;
        end
      end
      pawb_pkg::PC_RTB: begin
        if (we && !rto_enable) begin
          k_lo = pawb_pkg::K_ONE;
          k_hi = pawb_pkg::K_ONE;
        end
      end
      pawb_pkg::PC_SBST: begin
        if (!we) begin
          k_lo = pawb_pkg::K_ONE;
          k_hi = pawb_pkg::K_ONE;
        end
      end
      pawb_pkg::PC_CRC_DATA_IN: begin
        if (we) begin
          k_lo = pawb_pkg::K_ONE;
          k_hi = pawb_pkg::K_ONE;
        end
      end
      default: begin
        k_lo = pawb_pkg::K_NONE;
        k_hi = pawb_pkg::K_NONE;
      end
    endcase
  end
endmodule // pawb_kdec

/* logic/pawb_pkg.sv */
// constants, classes and decode for the peripheral access wait bridge
// Operation
// - stall the cpu while a peripheral access may collide with peripheral clock activity
// - add extra waits for special registers beyond the system wait setting
// - access clocks total three plus i plus j plus (two plus j) times k
// - i from upper four bits, j from lower four bits of wait setting
// - k of one or two for counter, compare, converter mode and result reads
// - compare write: first has no factor, back-to-back write uses three or four
// - watchdog mode write while watchdog runs uses k of three
// - k of one: rt buffer write when disabled, bus status read, crc write
// - wait started under a prohibited clock stays stalled until system reset
// - plain peripheral access without wait takes three cpu clocks
package pawb_pkg;

  localparam int PADDR_W = 16;
  localparam int PDATA_W = 16;
  localparam int AXI_AW  = 8;
  localparam int K_W     = 3;
  localparam int TOT_W   = 8;

  // register map of the bus slave
  localparam logic [AXI_AW-1:0] SWC_OFF  = 8'h00;
  localparam logic [AXI_AW-1:0] STAT_OFF = 8'h04;
  localparam logic [AXI_AW-1:0] ACNT_OFF = 8'h08;
  localparam logic [7:0]        SWC_RST  = 8'h77;
  localparam logic [1:0]        RESP_OK  = 2'b00;
  localparam logic [1:0]        RESP_ERR = 2'b10;

  // access cycle formula terms
  localparam logic [TOT_W-1:0] BASE_CYC   = 8'h03;
  localparam logic [TOT_W-1:0] STROBE_ADD = 8'h02;

  // k factors
  localparam logic [K_W-1:0] K_NONE  = 3'h0;
  localparam logic [K_W-1:0] K_ONE   = 3'h1;
  localparam logic [K_W-1:0] K_TWO   = 3'h2;
  localparam logic [K_W-1:0] K_THREE = 3'h3;
  localparam logic [K_W-1:0] K_FOUR  = 3'h4;

  typedef enum logic [3:0] {
    PC_OTHER, PC_TCNT, PC_TCMP, PC_WDM, PC_RTB, PC_CMODE, PC_CRES, PC_CRESH,
    PC_SBST, PC_CRC_DATA_IN
  } pawb_class_t;

  // peripheral address windows of the special registers
  localparam logic [PADDR_W-1:0] TCNT_LO  = 16'h0100;
  localparam logic [PADDR_W-1:0] TCNT_HI  = 16'h010f;
  localparam logic [PADDR_W-1:0] TCMP_LO  = 16'h0110;
  localparam logic [PADDR_W-1:0] TCMP_HI  = 16'h012f;
  localparam logic [PADDR_W-1:0] WDM_ADR  = 16'h0200;
  localparam logic [PADDR_W-1:0] RTB_LO   = 16'h0300;
  localparam logic [PADDR_W-1:0] RTB_HI   = 16'h0301;
  localparam logic [PADDR_W-1:0] CMODE_AD = 16'h0400;
  localparam logic [PADDR_W-1:0] CRES_LO  = 16'h0410;
  localparam logic [PADDR_W-1:0] CRES_HI  = 16'h041b;
  localparam logic [PADDR_W-1:0] CRESH_LO = 16'h0420;
  localparam logic [PADDR_W-1:0] CRESH_HI = 16'h042b;
  localparam logic [PADDR_W-1:0] SBST_LO  = 16'h0500;
  localparam logic [PADDR_W-1:0] SBST_HI  = 16'h0502;
  localparam logic [PADDR_W-1:0] CRC_DATA_IN_ADR = 16'h0600;

  function automatic pawb_class_t pawb_decode(input logic [PADDR_W-1:0] a);
    pawb_class_t c;
    c = PC_OTHER;
    if (a >= TCNT_LO && a <= TCNT_HI) c = PC_TCNT;
    else if (a >= TCMP_LO && a <= TCMP_HI) c = PC_TCMP;
    else if (a == WDM_ADR) c = PC_WDM;
    else if (a >= RTB_LO && a <= RTB_HI) c = PC_RTB;
    else if (a == CMODE_AD) c = PC_CMODE;
    else if (a >= CRES_LO && a <= CRES_HI) c = PC_CRES;
    else if (a >= CRESH_LO && a <= CRESH_HI) c = PC_CRESH;
    else if (a >= SBST_LO && a <= SBST_HI) c = PC_SBST;
    else if (a == CRC_DATA_IN_ADR) c = PC_CRC_DATA_IN;
    return c;
  endfunction

endpackage

/* logic/pawb_sync.sv */
// two-flop synchroniser for inputs from the peripheral clock domain and pins
`timescale 1ns/1ps
module pawb_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule // pawb_sync

/* testbench/pawb_periph_model.sv */
// peripheral register slave model answering straight from the address
`timescale 1ns/1ps
module pawb_periph_model (
  input  wire logic [pawb_pkg::PADDR_W-1:0] per_addr,
  input  wire logic                         per_sel,
  output logic      [pawb_pkg::PDATA_W-1:0] per_rdata
);
  logic [pawb_pkg::PDATA_W-1:0] last_val;

  initial last_val = 16'h0000;

  // a released bus shows the inverse, so a stale sample never passes
  always @(per_sel or per_addr) begin
    if (per_sel) begin
      last_val = per_addr ^ 16'h5a5a;
      per_rdata = last_val;
    end else begin
      per_rdata = ~last_val;
    end
  end
endmodule // pawb_periph_model

/* testbench/tb_peripheral_access_wait_bridge.sv */
// self-checking bench for the peripheral access wait bridge
`timescale 1ns/1ps
module tb_peripheral_access_wait_bridge;
  typedef struct packed {
    logic [15:0] a;
    logic [3:0]  fl;
    logic [7:0]  swc;
    logic [2:0]  k;
  } pawb_row_t;
  // flags: write, watchdog running, rt enable, pclk level
  localparam pawb_row_t ROWS [20] = '{
    {16'h0700, 4'h0, 8'h00, 3'h0}, {16'h0100, 4'h0, 8'h00, 3'h1},
    {16'h0100, 4'h1, 8'h00, 3'h2}, {16'h0118, 4'h0, 8'h00, 3'h1},
    {16'h0400, 4'h1, 8'h00, 3'h2}, {16'h0415, 4'h0, 8'h00, 3'h1},
    {16'h042b, 4'h0, 8'h00, 3'h1}, {16'h0501, 4'h0, 8'h00, 3'h1},
    {16'h0600, 4'h8, 8'h00, 3'h1}, {16'h0300, 4'h8, 8'h00, 3'h1},
    {16'h0301, 4'ha, 8'h00, 3'h0}, {16'h0200, 4'hc, 8'h00, 3'h3},
    {16'h0200, 4'h8, 8'h00, 3'h0}, {16'h0110, 4'h8, 8'h00, 3'h0},
    {16'h0120, 4'h8, 8'h00, 3'h3}, {16'h012f, 4'h9, 8'h00, 3'h4},
    {16'h0700, 4'h0, 8'h01, 3'h0}, {16'h0100, 4'h1, 8'h01, 3'h2},
    {16'h0110, 4'h8, 8'h01, 3'h0}, {16'h0111, 4'h8, 8'h01, 3'h3}};

  logic        clk, rstn, cpu_req, cpu_we, cpu_wait, cpu_done, pclk_in, per_sel, per_we;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] cpu_addr, cpu_wdata, cpu_rdata, per_addr, per_wdata, per_rdata;
  logic        wdt_running, rto_enable, sub_main_stopped, on_internal_osc;
  logic [7:0]  swc_now;
  logic        cmpw;
  pawb_row_t   row;
  int          miscompares, comparisons, cycles, n;

  pawb_bridge DUT (
    .clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .cpu_req, .cpu_we, .cpu_addr, .cpu_wdata, .cpu_wait, .cpu_done, .cpu_rdata, .pclk_in,
    .per_sel, .per_we, .per_addr, .per_wdata, .per_rdata, .wdt_running, .rto_enable,
    .sub_main_stopped, .on_internal_osc);

  pawb_periph_model PERIPH (.per_addr, .per_sel, .per_rdata);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [7:0] exp_cyc(input logic [7:0] s, input logic [2:0] k);
    return 8'h03 + {4'h0, s[7:4]} + {4'h0, s[3:0]} + (8'h02 + {4'h0, s[3:0]}) * {5'h00, k};
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic do_reset;
    @(posedge clk);
    rstn <= 1'b0;
    sub_main_stopped <= 1'b0;
    on_internal_osc <= 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // request held steady until done or the limit; n counts edges from take
  task automatic cpu_acc(input logic [15:0] a, input logic we, input logic stk);
    @(posedge clk);
    cpu_addr <= a;
    cpu_we <= we;
    cpu_wdata <= ~a;
    cpu_req <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (n == 1 && stk) check({cpu_wait, per_sel}, 2'b10, "stuck take");
      else if (n == 1) check({cpu_wait, per_sel, per_we, per_addr, per_wdata},
                             {2'b11, we, a, ~a}, "stall");
    end while (cpu_done !== 1'b1 && n < (stk ? 60 : 200));
    if (!stk) check(cpu_wait, 1'b0, "wait after done");
    @(posedge clk);
    cpu_req <= 1'b0;
  endtask

  initial begin
    {rstn, cpu_req, cpu_we, pclk_in, wdt_running, rto_enable} = '0;
    {sub_main_stopped, on_internal_osc, cpu_addr, cpu_wdata} = '0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    {miscompares, comparisons, cycles} = '0;
    do_reset();
    axi_rd(pawb_pkg::SWC_OFF);
    check({rsp, d}, {pawb_pkg::RESP_OK, 24'h0, pawb_pkg::SWC_RST}, "wait reset value");
    axi_wr(8'h40, 32'h0, 4'hf);
    check(rsp, pawb_pkg::RESP_ERR, "unmapped write");
    axi_rd(8'h40);
    check({rsp, d}, {pawb_pkg::RESP_ERR, 32'h0}, "unmapped read");
    $display("register bus test done");
    swc_now = pawb_pkg::SWC_RST;
    for (int r = 0; r < 20; r++) begin
      row = ROWS[r];
      if (row.swc !== swc_now) axi_wr(pawb_pkg::SWC_OFF, {24'h0, row.swc}, 4'hf);
      swc_now = row.swc;
      @(posedge clk);
      wdt_running <= row.fl[2];
      rto_enable <= row.fl[1];
      pclk_in <= row.fl[0];
      // let the pclk level pass the synchroniser first
      repeat (3) @(posedge clk);
      cpu_acc(row.a, row.fl[3], 1'b0);
      check(n, exp_cyc(row.swc, row.k), "access clocks");
      if (!row.fl[3]) check(cpu_rdata, row.a ^ 16'h5a5a, "read data");
      axi_rd(pawb_pkg::STAT_OFF);
      cmpw = row.fl[3] && row.a >= pawb_pkg::TCMP_LO && row.a <= pawb_pkg::TCMP_HI;
      check(d[15:0], {2'b00, cmpw, 2'b00, row.k, exp_cyc(row.swc, row.k)},
            "status");
      $display("row %0d done", r);
    end
    axi_wr(pawb_pkg::STAT_OFF, 32'h0000_0000, 4'hf);
    check(rsp, pawb_pkg::RESP_OK, "status write ignored");
    axi_rd(pawb_pkg::ACNT_OFF);
    check({rsp, d}, {pawb_pkg::RESP_OK, 32'h0000_0014}, "access count");
    // only the low strobe may touch the wait setting
    axi_wr(pawb_pkg::SWC_OFF, 32'h0000_0000, 4'he);
    axi_rd(pawb_pkg::SWC_OFF);
    check(d, 32'h1, "strobe ignored");
    $display("strobe test done");
    for (int c = 0; c < 2; c++) begin
      @(posedge clk);
      sub_main_stopped <= (c == 0);
      on_internal_osc <= (c == 1);
      repeat (3) @(posedge clk);
      cpu_acc(16'h0100, 1'b0, 1'b1);
      check({cpu_done, cpu_wait}, 2'b01, "stuck stall");
      axi_rd(pawb_pkg::STAT_OFF);
      check(d[15:14], 2'b11, "stuck flag");
      do_reset();
      #1;
      check(cpu_wait, 1'b0, "released by reset");
      axi_rd(pawb_pkg::SWC_OFF);
      check(d, {24'h0, pawb_pkg::SWC_RST}, "wait value after reset");
      $display("stuck test %0d done", c);
    end
    report_and_stop();
  end
endmodule // tb_peripheral_access_wait_bridge
